// >>> cfg_ctl.sv
// control-field interpreter with wishbone status and drop-count registers
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`default_nettype none
module cfg_ctl (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [7:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic parity_enable,
  input wire logic [23:0] cfg_pins,
  output logic [7:0] codec_data,
  output logic codec_valid,
  output logic codec_last,
  input wire logic codec_ready,
  output logic codec_rst_n,
  output logic [15:0] drop_count,
  input wire cfg_ctl_pkg::wb_req_s wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ----------------------------------------------------------------------
  // field decoding
  // ----------------------------------------------------------------------
  function automatic logic [2:0] arg_len(input logic [7:0] id);
    unique case (id)
      cfg_ctl_pkg::ID_SOFT_CFG: arg_len = cfg_ctl_pkg::ARGS_SOFT;
      cfg_ctl_pkg::ID_PARITY: arg_len = cfg_ctl_pkg::ARGS_ONE;
      cfg_ctl_pkg::ID_CODEC_WR: arg_len = cfg_ctl_pkg::ARGS_ONE;
      cfg_ctl_pkg::ID_DROP: arg_len = cfg_ctl_pkg::ARGS_TWO;
      cfg_ctl_pkg::ID_PAUSE: arg_len = cfg_ctl_pkg::ARGS_TWO;
      default: arg_len = cfg_ctl_pkg::ARGS_NONE;
    endcase
  endfunction

  cfg_ctl_pkg::ctl_s r;
  cfg_ctl_pkg::ctl_s n;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic fire;
    logic take;
    logic [47:0] a;
    logic [23:0] c;
    logic [23:0] m;
    fire = 1'b0;
    take = in_valid && r.in_ready;
    a = r.arg;
    c = 24'h000000;
    m = 24'h000000;
    n = r;
    // pin synchroniser: first stage feeds only the second
    n.pin_meta = cfg_pins;
    n.pin_sync = r.pin_meta;
    unique case (r.state)
      cfg_ctl_pkg::ST_WAKE:
      begin
        n.wake_cnt = r.wake_cnt + 2'h1;
        if (r.wake_cnt == cfg_ctl_pkg::WAKE_SYNC)
        begin
          n.latched = (r.soft_cfg & r.soft_mask) |
                      (r.pin_sync & ~r.soft_mask);
          n.parity_on = n.latched[cfg_ctl_pkg::PARITY_BIT];
          n.rbuf = {24'h000000, cfg_ctl_pkg::ID_READY};
          n.rlen = cfg_ctl_pkg::REPLY_ACK;
          n.cmd = cfg_ctl_pkg::ID_READY;
          n.state = cfg_ctl_pkg::ST_REPLY;
        end
      end
      cfg_ctl_pkg::ST_IDLE:
      begin
        if (take)
        begin
          n.cmd = in_data;
          n.arg_left = arg_len(in_data);
          if (arg_len(in_data) == cfg_ctl_pkg::ARGS_NONE)
            fire = 1'b1;
          else
            n.state = cfg_ctl_pkg::ST_ARG;
        end
      end
      cfg_ctl_pkg::ST_ARG:
      begin
        if (take)
        begin
          a = {r.arg[39:0], in_data};
          n.arg = a;
          n.arg_left = r.arg_left - 3'h1;
          if (r.arg_left == cfg_ctl_pkg::ARGS_ONE)
            fire = 1'b1;
        end
      end
      cfg_ctl_pkg::ST_CODEC:
      begin
        if (r.codec_valid && codec_ready)
        begin
          n.codec_valid = 1'b0;
          if (r.codec_last)
          begin
            n.rbuf = {24'h000000, r.cmd};
            n.rlen = cfg_ctl_pkg::REPLY_ACK;
            n.state = cfg_ctl_pkg::ST_REPLY;
          end
        end
        else if (take)
        begin
          // forwarding codec bytes unchanged, one at a time
          n.codec_data = in_data;
          n.codec_valid = 1'b1;
          n.codec_last = r.codec_left == 8'h01;
          n.codec_left = r.codec_left - 8'h01;
        end
      end
      cfg_ctl_pkg::ST_REPLY:
      begin
        if (out_ready)
        begin
          n.rbuf = {8'h00, r.rbuf[31:8]};
          n.rlen = r.rlen - 3'h1;
          if (r.rlen == cfg_ctl_pkg::REPLY_ACK)
          begin
            // the pause starts only once its acknowledgment is out
            if (r.cmd == cfg_ctl_pkg::ID_PAUSE && r.pause_left != 16'h0000)
              n.state = cfg_ctl_pkg::ST_PAUSE;
            else
              n.state = cfg_ctl_pkg::ST_IDLE;
          end
        end
      end
      cfg_ctl_pkg::ST_PAUSE:
      begin
        n.us_cnt = r.us_cnt + 7'h01;
        if (r.us_cnt == cfg_ctl_pkg::US_LAST)
        begin
          n.us_cnt = 7'h00;
          n.pause_left = r.pause_left - 16'h0001;
          if (r.pause_left == 16'h0001)
            n.state = cfg_ctl_pkg::ST_IDLE;
        end
      end
    endcase

    // execute a complete field
    if (fire)
    begin
      n.state = cfg_ctl_pkg::ST_REPLY;
      n.rlen = cfg_ctl_pkg::REPLY_ACK;
      n.rbuf = {24'h000000, n.cmd};
      unique case (n.cmd)
        cfg_ctl_pkg::ID_SOFT_CFG:
        begin
          // no acknowledgment; reset then ready notice
          c = {a[31:24], a[39:32], a[47:40]};
          m = {a[7:0], a[15:8], a[23:16]};
          n.soft_cfg = c;
          n.soft_mask = m;
          n.codec_rst_n = 1'b1;
          n.drop = cfg_ctl_pkg::DROP_RST;
          n.wake_cnt = 2'h0;
          n.state = cfg_ctl_pkg::ST_WAKE;
        end
        cfg_ctl_pkg::ID_REPORT_CFG:
        begin
          n.rbuf = {r.latched, cfg_ctl_pkg::ID_REPORT_CFG};
          n.rlen = cfg_ctl_pkg::REPLY_CFG;
        end
        cfg_ctl_pkg::ID_SAMPLE_CFG:
        begin
          // live pins go to the reply only
          n.rbuf = {r.pin_sync, cfg_ctl_pkg::ID_SAMPLE_CFG};
          n.rlen = cfg_ctl_pkg::REPLY_CFG;
        end
        cfg_ctl_pkg::ID_PARITY:
          n.parity_on = a[0];
        cfg_ctl_pkg::ID_CODEC_WR:
        begin
          n.codec_left = a[7:0];
          if (a[7:0] != 8'h00)
            n.state = cfg_ctl_pkg::ST_CODEC;
        end
        cfg_ctl_pkg::ID_CODEC_CLR:
          n.codec_rst_n = 1'b0;
        cfg_ctl_pkg::ID_CODEC_SET:
          n.codec_rst_n = 1'b1;
        cfg_ctl_pkg::ID_DROP:
          n.drop = a[15:0];
        cfg_ctl_pkg::ID_PAUSE:
        begin
          n.pause_left = a[15:0];
          n.us_cnt = 7'h00;
        end
        default:
          n.state = cfg_ctl_pkg::ST_IDLE;
      endcase
    end

    // wishbone slave: one wait state, unmapped reads as zero
    // a write lands at the edge at which the master sees ack high; it is lost if a field completes in that cycle
    n.ack = wb_req.cyc && wb_req.stb && !r.ack;
    if (r.ack && wb_req.cyc && wb_req.stb && wb_req.we &&
        wb_req.adr == cfg_ctl_pkg::OFS_DROP && !fire)
    begin
      if (wb_req.sel[0])
        n.drop[7:0] = wb_req.dat[7:0];
      if (wb_req.sel[1])
        n.drop[15:8] = wb_req.dat[15:8];
    end
    n.rdat = 32'h00000000;
    unique case (wb_req.adr)
      cfg_ctl_pkg::OFS_STATUS:
        n.rdat[2:0] = {r.state != cfg_ctl_pkg::ST_IDLE, r.codec_rst_n,
                       r.parity_on};
      cfg_ctl_pkg::OFS_DROP:
        n.rdat[15:0] = r.drop;
      cfg_ctl_pkg::OFS_LATCHED:
        n.rdat[23:0] = r.latched;
      cfg_ctl_pkg::OFS_LIVE:
        n.rdat[23:0] = r.pin_sync;
      default:
        n.rdat = 32'h00000000;
    endcase

    n.out_valid = n.state == cfg_ctl_pkg::ST_REPLY;
    n.in_ready = n.state == cfg_ctl_pkg::ST_IDLE ||
                 n.state == cfg_ctl_pkg::ST_ARG ||
                 (n.state == cfg_ctl_pkg::ST_CODEC && !n.codec_valid);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
      r.state <= cfg_ctl_pkg::ST_WAKE;
      r.codec_rst_n <= 1'b1;
      r.drop <= cfg_ctl_pkg::DROP_RST;
    end
    else
      r <= n;
  end

  assign in_ready = r.in_ready;
  assign out_data = r.rbuf[7:0];
  assign out_valid = r.out_valid;
  assign parity_enable = r.parity_on;
  assign codec_data = r.codec_data;
  assign codec_valid = r.codec_valid;
  assign codec_last = r.codec_last;
  assign codec_rst_n = r.codec_rst_n;
  assign drop_count = r.drop;
  assign wb_dat_o = r.rdat;
  assign wb_ack_o = r.ack;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_take_id(logic [7:0] id);
    r.state == cfg_ctl_pkg::ST_IDLE && in_valid && r.in_ready &&
    in_data == id;
  endsequence

  sequence s_last_arg(logic [7:0] id);
    r.state == cfg_ctl_pkg::ST_ARG && in_valid && r.in_ready &&
    r.cmd == id && r.arg_left == cfg_ctl_pkg::ARGS_ONE;
  endsequence

  chk_report_latched: assert property (
    s_take_id(cfg_ctl_pkg::ID_REPORT_CFG) |=> out_valid &&
    out_data == cfg_ctl_pkg::ID_REPORT_CFG &&
    r.rbuf[31:8] == $past(r.latched) && r.rlen == cfg_ctl_pkg::REPLY_CFG)
    else $error("report reply wrong");

  chk_report_no_sample: assert property (
    s_take_id(cfg_ctl_pkg::ID_REPORT_CFG) |=> $stable(r.latched))
    else $error("report changed latched config");

  chk_sample_live: assert property (
    s_take_id(cfg_ctl_pkg::ID_SAMPLE_CFG) |=>
    r.rbuf == {$past(r.pin_sync), cfg_ctl_pkg::ID_SAMPLE_CFG})
    else $error("sample reply not live pins");

  chk_sample_keeps_cfg: assert property (
    s_take_id(cfg_ctl_pkg::ID_SAMPLE_CFG) |=>
    $stable(r.latched) && $stable(r.parity_on))
    else $error("sample changed configuration");

  chk_parity_ack: assert property (
    s_last_arg(cfg_ctl_pkg::ID_PARITY) |=> out_valid &&
    out_data == cfg_ctl_pkg::ID_PARITY && r.rlen == cfg_ctl_pkg::REPLY_ACK &&
    parity_enable == $past(in_data[0]))
    else $error("parity field not applied before its ack");

  chk_softcfg_no_ack: assert property (
    s_last_arg(cfg_ctl_pkg::ID_SOFT_CFG) |=>
    (r.state == cfg_ctl_pkg::ST_WAKE && !out_valid) [*3] ##1
    out_valid && out_data == cfg_ctl_pkg::ID_READY)
    else $error("soft reset reply wrong");

  chk_codec_low: assert property (
    s_take_id(cfg_ctl_pkg::ID_CODEC_CLR) |=> !codec_rst_n &&
    out_data == cfg_ctl_pkg::ID_CODEC_CLR)
    else $error("codec reset not driven low");

  chk_drop_set: assert property (
    s_last_arg(cfg_ctl_pkg::ID_DROP) |=>
    drop_count == {$past(r.arg[7:0]), $past(in_data)})
    else $error("drop count not stored");

  chk_pause_hold: assert property (
    r.state == cfg_ctl_pkg::ST_PAUSE |-> !in_ready && !out_valid)
    else $error("field taken during pause");

  chk_codec_hold: assert property (
    codec_valid && !codec_ready |=> codec_valid && $stable(codec_data))
    else $error("codec byte dropped");
endmodule
`default_nettype wire

// >>> cfg_ctl_pkg.sv
// constants and types for the control-field interpreter
// ----------------------------------------------------------------------
// How it works
// - soft-config reset field gets no acknowledgment; the ready notice replies.
// - report field 0x36 replies 0x36 plus the three bytes latched at reset.
// - report field never resamples the pins; reply uses reset-time values.
// - sample field 0x37 samples pins on receipt, replies 0x37 plus three bytes.
// - sample reply shows current pin levels even when they differ from reset.
// - sampling pins leaves the active configuration unchanged.
// - parity mode 0 stops output parity from this reply; input parity optional.
// - parity mode 1 adds output parity from this reply; rejects unchecked input.
// - parity field is acknowledged by 0x3F alone.
// - codec write field 0x44, length n, n bytes to codec; acknowledged 0x44.
// - field 0x46 drives codec reset low and acknowledges 0x46.
// - field 0x47 updates codec reset output and acknowledges 0x47.
// - field 0x48 sets two-byte startup drop count, default 0, acknowledged.
// - pause field waits the given microseconds before the next field.
// - pause field is 0x49 plus two-byte count; acknowledged by 0x49.
// - after any reset a ready notice 0x39 is sent once packets are accepted.
// - three config bytes hold one bit per each of 24 pins.
// ----------------------------------------------------------------------
`default_nettype none
package cfg_ctl_pkg;
  localparam logic [7:0] ID_SOFT_CFG = 8'h34;
  localparam logic [7:0] ID_REPORT_CFG = 8'h36;
  localparam logic [7:0] ID_SAMPLE_CFG = 8'h37;
  localparam logic [7:0] ID_READY = 8'h39;
  localparam logic [7:0] ID_PARITY = 8'h3F;
  localparam logic [7:0] ID_CODEC_WR = 8'h44;
  localparam logic [7:0] ID_CODEC_CLR = 8'h46;
  localparam logic [7:0] ID_CODEC_SET = 8'h47;
  localparam logic [7:0] ID_DROP = 8'h48;
  localparam logic [7:0] ID_PAUSE = 8'h49;
  localparam logic [2:0] ARGS_SOFT = 3'h6;
  localparam logic [2:0] ARGS_ONE = 3'h1;
  localparam logic [2:0] ARGS_TWO = 3'h2;
  localparam logic [2:0] ARGS_NONE = 3'h0;
  localparam logic [2:0] REPLY_ACK = 3'h1;
  localparam logic [2:0] REPLY_CFG = 3'h4;
  localparam int PARITY_BIT = 20;
  localparam int CLK_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = US_NS / CLK_NS;
  localparam logic [6:0] US_LAST = 7'(US_CYCLES - 1);
  localparam logic [1:0] WAKE_SYNC = 2'h2;
  localparam logic [15:0] DROP_RST = 16'h0000;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_DROP = 8'h04;
  localparam logic [7:0] OFS_LATCHED = 8'h08;
  localparam logic [7:0] OFS_LIVE = 8'h0C;

  typedef enum logic [2:0] {
    ST_WAKE, ST_IDLE, ST_ARG, ST_CODEC, ST_REPLY, ST_PAUSE
  } fsm_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    fsm_e state;
    logic [7:0] cmd;
    logic [2:0] arg_left;
    logic [47:0] arg;
    logic [23:0] pin_meta;
    logic [23:0] pin_sync;
    logic [23:0] latched;
    logic [23:0] soft_cfg;
    logic [23:0] soft_mask;
    logic [1:0] wake_cnt;
    logic parity_on;
    logic codec_rst_n;
    logic [15:0] drop;
    logic [15:0] pause_left;
    logic [6:0] us_cnt;
    logic [31:0] rbuf;
    logic [2:0] rlen;
    logic out_valid;
    logic in_ready;
    logic [7:0] codec_data;
    logic codec_valid;
    logic codec_last;
    logic [7:0] codec_left;
    logic ack;
    logic [31:0] rdat;
  } ctl_s;
endpackage
`default_nettype wire

// >>> codec_sink.sv
// byte sink standing in for the codec-side serial master
`default_nettype none
module codec_sink (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] codec_data,
  input wire logic codec_valid,
  input wire logic codec_last,
  output var logic codec_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got[$];
  logic last_seen;
  // takes bytes at random moments, so both prompt and slow answers occur
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      codec_ready <= 1'b0;
      last_seen <= 1'b0;
    end
    else
    begin
      if (codec_valid && codec_ready)
      begin
        got.push_back(codec_data);
        last_seen <= codec_last;
      end
      codec_ready <= ($urandom % 3) == 0;
    end
  end
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the control-field interpreter
`default_nettype none
`define CHK(a, b) \
  begin \
    n_checks++; \
    if ((a) !== (b)) \
    begin \
      errors++; \
      $display("BAD %0t got %h want %h", $time, (a), (b)); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rst, in_valid, in_ready, out_valid, out_ready;
  logic parity_enable, codec_valid, codec_last, codec_ready, codec_rst_n;
  logic wb_ack_o;
  logic [7:0] in_data, out_data, codec_data, got;
  logic [23:0] cfg_pins, lat, live, sc;
  logic [15:0] drop_count;
  logic [31:0] wb_dat_o, rd;
  logic [7:0] exp_q[$];
  logic [7:0] d[3];
  cfg_ctl_pkg::wb_req_s wb_req;
  int errors, n_checks, cyc, t_take;

  cfg_ctl DUT (.ref_clk(ref_clk), .rst(rst), .in_data(in_data),
    .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready),
    .parity_enable(parity_enable), .cfg_pins(cfg_pins),
    .codec_data(codec_data), .codec_valid(codec_valid),
    .codec_last(codec_last), .codec_ready(codec_ready),
    .codec_rst_n(codec_rst_n), .drop_count(drop_count),
    .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  codec_sink CM (.ref_clk(ref_clk), .rst(rst), .codec_data(codec_data),
    .codec_valid(codec_valid), .codec_last(codec_last),
    .codec_ready(codec_ready));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // reply sink stalls at random; also the hang limit
  always @(posedge ref_clk)
  begin
    out_ready <= ($urandom % 4) != 0;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      $display("BAD %0t timeout", $time);
      print_verdict();
    end
  end

  // compares every accepted reply byte with the oldest expectation
  always @(posedge ref_clk)
  begin
    if (out_valid === 1'b1 && out_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        errors++;
        $display("BAD %0t unexpected reply %h", $time, out_data);
      end
      else
      begin
        got = exp_q.pop_front();
        `CHK(out_data, got)
      end
    end
  end

  task automatic field(input logic [7:0] b[$]);
    foreach (b[i])
    begin
      in_data <= b[i];
      in_valid <= 1'b1;
      do @(posedge ref_clk); while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
    t_take = cyc;
    while (exp_q.size() != 0) @(posedge ref_clk);
    @(posedge ref_clk);
  endtask

  task automatic exp_cfg(input logic [7:0] id, input logic [23:0] v);
    exp_q.push_back(id);
    exp_q.push_back(v[7:0]);
    exp_q.push_back(v[15:8]);
    exp_q.push_back(v[23:16]);
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] dt);
    wb_req <= '{1'b1, 1'b1, w, a, 4'hF, dt};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_req <= '0;
    @(posedge ref_clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h3FEC));
    rst = 1'b1;
    in_valid = 1'b0;
    in_data = 8'h00;
    wb_req = '0;
    lat = 24'($urandom);
    cfg_pins = lat;
    exp_q.push_back(cfg_ctl_pkg::ID_READY);
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    while (exp_q.size() != 0) @(posedge ref_clk);
    `CHK(parity_enable, lat[20])
    $display("test reset done");
    cfg_pins <= 24'($urandom);
    exp_cfg(cfg_ctl_pkg::ID_REPORT_CFG, lat);
    field({cfg_ctl_pkg::ID_REPORT_CFG});
    $display("test report done");
    live = 24'($urandom);
    cfg_pins <= live;
    repeat (4) @(posedge ref_clk);
    exp_cfg(cfg_ctl_pkg::ID_SAMPLE_CFG, live);
    field({cfg_ctl_pkg::ID_SAMPLE_CFG});
    `CHK(parity_enable, lat[20])
    exp_cfg(cfg_ctl_pkg::ID_REPORT_CFG, lat);
    field({cfg_ctl_pkg::ID_REPORT_CFG});
    $display("test sample done");
    for (int m = 1; m >= 0; m--)
    begin
      exp_q.push_back(cfg_ctl_pkg::ID_PARITY);
      field({cfg_ctl_pkg::ID_PARITY, 8'(m)});
      `CHK(parity_enable, m[0])
    end
    $display("test parity done");
    foreach (d[i]) d[i] = 8'($urandom);
    exp_q.push_back(cfg_ctl_pkg::ID_CODEC_WR);
    field({cfg_ctl_pkg::ID_CODEC_WR, 8'h03, d[0], d[1], d[2]});
    `CHK(CM.got.size(), 3)
    foreach (d[i]) `CHK(CM.got[i], d[i])
    `CHK(CM.last_seen, 1'b1)
    exp_q.push_back(cfg_ctl_pkg::ID_CODEC_CLR);
    field({cfg_ctl_pkg::ID_CODEC_CLR});
    `CHK(codec_rst_n, 1'b0)
    exp_q.push_back(cfg_ctl_pkg::ID_CODEC_SET);
    field({cfg_ctl_pkg::ID_CODEC_SET});
    `CHK(codec_rst_n, 1'b1)
    $display("test codec done");
    `CHK(drop_count, 16'h0000)
    exp_q.push_back(cfg_ctl_pkg::ID_DROP);
    field({cfg_ctl_pkg::ID_DROP, 8'h00, 8'h80});
    `CHK(drop_count, 16'h0080)
    wb(1'b0, 8'h04, 32'h0000_0000);
    `CHK(rd, 32'h0000_0080)
    wb(1'b1, 8'h04, 32'h0000_1234);
    `CHK(drop_count, 16'h1234)
    wb(1'b0, 8'h10, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    wb(1'b0, 8'h08, 32'h0000_0000);
    `CHK(rd, {8'h00, lat})
    wb(1'b0, 8'h00, 32'h0000_0000);
    `CHK(rd, 32'h0000_0002)
    $display("test registers done");
    exp_q.push_back(cfg_ctl_pkg::ID_PAUSE);
    field({cfg_ctl_pkg::ID_PAUSE, 8'h00, 8'h02});
    while (in_ready !== 1'b1) @(posedge ref_clk);
    `CHK((cyc - t_take) inside {[200:240]}, 1'b1)
    $display("test pause done");
    sc = 24'($urandom);
    exp_q.push_back(cfg_ctl_pkg::ID_READY);
    field({cfg_ctl_pkg::ID_SOFT_CFG, sc[7:0], sc[15:8], sc[23:16],
      8'hF0, 8'h00, 8'hFF});
    lat = (sc & 24'hFF00F0) | (live & ~24'hFF00F0);
    `CHK(parity_enable, lat[20])
    `CHK(drop_count, 16'h0000)
    exp_cfg(cfg_ctl_pkg::ID_REPORT_CFG, lat);
    field({cfg_ctl_pkg::ID_REPORT_CFG});
    $display("test soft reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
